// ==== design/sri_pkg.sv ====
package sri_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int MCLK_PERIOD_NS     = 10;
    localparam int MACHINE_CYCLE_NS   = 10;
    localparam int RST_LOW_MIN_MC     = 1;
    localparam int RST_LOW_MIN_NS     = RST_LOW_MIN_MC * MACHINE_CYCLE_NS;
    localparam int RST_LOW_CYCLES_RAW = (RST_LOW_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int RST_LOW_CYCLES     = (RST_LOW_CYCLES_RAW < 1) ? 1 : RST_LOW_CYCLES_RAW;
    localparam int LOW_CNT_W          = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int PC_W    = 14;
    localparam int NIB_W   = 4;
    localparam int LATCH_W = 24;
    localparam int STRUC_W = 15;
    localparam int GEN_W   = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in the port latch vector
    localparam int LAT_D_LSB  = 0;
    localparam int LAT_P0_LSB = 7;
    localparam int LAT_P1_LSB = 11;
    localparam int LAT_P2_LSB = 15;
    localparam int LAT_P3_LSB = 18;
    localparam int LAT_P6_LSB = 20;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic {SRI_RESET, SRI_RUN} sri_phase_t;

    typedef enum logic [1:0] {OSC_ONCHIP, OSC_CERAMIC, OSC_RC, OSC_QUARTZ} sri_osc_t;

    typedef enum logic [3:0] {
        SEL_IRQ_CTRL_A, SEL_IRQ_CTRL_B, SEL_EXT_IRQ_CFG_A, SEL_TMR_CTRL_SIX,
        SEL_CLOCK_MODE, SEL_ADC_CTRL_A, SEL_ADC_CTRL_B, SEL_WAKEUP_CTRL_A,
        SEL_WAKEUP_CTRL_B, SEL_PULLUP_CTRL_A, SEL_PULLUP_CTRL_B
    } sri_sel_t;

    typedef struct packed {
        logic global_irq_enable;
        logic ext0_irq_request;
        logic ext1_irq_request;
        logic tmr1_irq_request;
        logic tmr2_irq_request;
        logic tmr3_irq_request;
        logic tmr4_irq_request;
        logic wdog_flag_a;
        logic wdog_flag_b;
        logic wdog_enable_flag;
        logic adc_done_flag;
        logic power_down_flag;
    } sri_flags_t;

    typedef struct packed {
        logic [NIB_W-1:0] irq_ctrl_a;
        logic [NIB_W-1:0] irq_ctrl_b;
        logic [NIB_W-1:0] ext_irq_cfg_a;
        logic [NIB_W-1:0] tmr_ctrl_six;
        logic [NIB_W-1:0] clock_mode_reg;
        logic [NIB_W-1:0] adc_ctrl_a;
        logic [NIB_W-1:0] adc_ctrl_b;
        logic [NIB_W-1:0] wakeup_ctrl_a;
        logic [NIB_W-1:0] wakeup_ctrl_b;
        logic [NIB_W-1:0] pullup_ctrl_a;
        logic [NIB_W-1:0] pullup_ctrl_b;
    } sri_ctrl_t;

    typedef struct packed {
        sri_phase_t           phase;
        logic [LOW_CNT_W-1:0] low_cnt;
        logic [PC_W-1:0]      pc;
        sri_flags_t           flags;
        sri_ctrl_t            ctrl;
        logic [LATCH_W-1:0]   latch;
        logic [STRUC_W-1:0]   push_pull;
        sri_osc_t             osc;
        logic [GEN_W-1:0]     gen;
    } sri_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [PC_W-1:0]    PC_RST        = 14'h0000;
    localparam sri_flags_t         FLAGS_RST     = 12'h004;
    localparam logic [NIB_W-1:0]   NIB_ZERO      = 4'h0;
    localparam logic [NIB_W-1:0]   CLOCK_MODE_RST = 4'hf;
    localparam logic [LATCH_W-1:0] LATCH_RST     = 24'hffffff;
    localparam logic [STRUC_W-1:0] PUSH_PULL_RST = 15'h0000;
    localparam logic [GEN_W-1:0]   GEN_RST       = 8'h00;
    localparam logic [LOW_CNT_W-1:0] LOW_CNT_MAX = 4'hf;

endpackage

// ==== design/sri_reset_init.sv ====
// Operation
// - Reset pin low one machine cycle resets
// - Release starts execution at page 0 address 0
// - Program counter loaded with zeros during reset
// - Reset state unchanged at release
// - All port output latches set to one
// - D and P0/P1 become open-drain
// - P0 and P1 pull-ups switched off
// - Global interrupt enable cleared
// - Both external interrupt requests cleared
// - Interrupt control registers A and B zeroed
// - External interrupt config register A zeroed
// - Four timer interrupt requests cleared
// - Both watchdog flags cleared
// - Watchdog enable flag set to one
// - Timer control register six zeroed
// - Clock mode register set to ones
// - ADC done flag, control A/B zeroed
// - Wakeup control registers A and B zeroed
// - Both pull-up control registers zeroed
// - On-chip oscillator runs, others stopped
// - Uninitialised state undefined, software sets it
// - Pin reset leaves power-down flag zero
`timescale 1ns/1ps

module sri_reset_init
    import sri_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                     MCLK,
    input  wire logic                     RESETN,
    input  wire logic                     CE,
    // Reset sources (asynchronous)
    input  wire logic                     RESET_PIN_N,
    input  wire logic                     POR,
    // Program counter control from the core
    input  wire logic                     PC_STEP,
    input  wire logic                     PC_LOAD,
    input  wire logic [sri_pkg::PC_W-1:0] PC_VALUE,
    // Control register writes
    input  wire logic                     REG_WR,
    input  wire sri_pkg::sri_sel_t        REG_SEL,
    input  wire logic [sri_pkg::NIB_W-1:0] REG_WDATA,
    // Flag set and clear strobes
    input  wire sri_pkg::sri_flags_t      FLAG_SET,
    input  wire sri_pkg::sri_flags_t      FLAG_CLR,
    // Port latch and structure writes
    input  wire logic                     LATCH_WR,
    input  wire logic [sri_pkg::LATCH_W-1:0] LATCH_WDATA,
    input  wire logic                     STRUC_WR,
    input  wire logic [sri_pkg::STRUC_W-1:0] STRUC_WDATA,
    // Oscillator selection
    input  wire logic                     OSC_WR,
    input  wire sri_pkg::sri_osc_t        OSC_WSEL,
    // General byte register
    input  wire logic                     GEN_WR,
    input  wire logic [sri_pkg::GEN_W-1:0] GEN_WDATA,
    // Counter pin drive in normal operation
    input  wire logic                     COUNTER_DRIVE,
    input  wire logic                     COUNTER_DRIVE_EN,
    // Reset status
    output logic                          SYS_RESET_N,
    output logic                          CPU_RUN,
    output logic [sri_pkg::PC_W-1:0]      PROGRAM_COUNTER,
    // Internal state
    output sri_pkg::sri_flags_t           FLAGS,
    output sri_pkg::sri_ctrl_t            CTRL,
    output logic [sri_pkg::GEN_W-1:0]     GEN_BYTE,
    // Port pins
    output logic [sri_pkg::LATCH_W-1:0]   PORT_OUT,
    output logic [sri_pkg::LATCH_W-1:0]   PORT_OE,
    output logic                          COUNTER_IO_PIN_OUT,
    output logic                          COUNTER_IO_PIN_OE,
    output logic [sri_pkg::NIB_W-1:0]     P0_PULLUP,
    output logic [sri_pkg::NIB_W-1:0]     P1_PULLUP,
    // Oscillators
    output sri_pkg::sri_osc_t             OSC_SRC,
    output logic [3:0]                    OSC_RUN
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers

    logic pin_n_sync;
    logic por_sync;

    sri_sync #(.W(1), .RST(1'b1)) u_pin_sync (
        .MCLK   (MCLK),
        .RESETN (RESETN),
        .CE     (CE),
        .D      (RESET_PIN_N),
        .Q      (pin_n_sync)
    );

    // Power-on reset is held asserted while the block itself is in reset
    sri_sync #(.W(1), .RST(1'b1)) u_por_sync (
        .MCLK   (MCLK),
        .RESETN (RESETN),
        .CE     (CE),
        .D      (POR),
        .Q      (por_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State

    sri_state_t state;
    sri_state_t next_state;

    logic [LOW_CNT_W-1:0] low_inc;
    logic                 pin_qualified;
    logic                 sys_reset;

    localparam logic [LOW_CNT_W-1:0] LOW_CYCLES = LOW_CNT_W'(RST_LOW_CYCLES);

    always_comb begin
        low_inc = (state.low_cnt == LOW_CNT_MAX) ? LOW_CNT_MAX : state.low_cnt + 4'h1;
    end

    // A low shorter than the minimum is ignored; with a one-cycle minimum any low the synchroniser samples resets
    assign pin_qualified = !pin_n_sync && (low_inc >= LOW_CYCLES);
    assign sys_reset     = pin_qualified || por_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        next_state.low_cnt = pin_n_sync ? '0 : low_inc;

        if (sys_reset) begin
            next_state.phase = SRI_RESET;
            next_state.pc    = PC_RST;
            // Pin or power-on reset is a cold start
            next_state.flags = FLAGS_RST;
            next_state.ctrl.irq_ctrl_a     = NIB_ZERO;
            next_state.ctrl.irq_ctrl_b     = NIB_ZERO;
            next_state.ctrl.ext_irq_cfg_a  = NIB_ZERO;
            next_state.ctrl.tmr_ctrl_six   = NIB_ZERO;
            next_state.ctrl.clock_mode_reg = CLOCK_MODE_RST;
            next_state.ctrl.adc_ctrl_a     = NIB_ZERO;
            next_state.ctrl.adc_ctrl_b     = NIB_ZERO;
            next_state.ctrl.wakeup_ctrl_a  = NIB_ZERO;
            next_state.ctrl.wakeup_ctrl_b  = NIB_ZERO;
            next_state.ctrl.pullup_ctrl_a  = NIB_ZERO;
            next_state.ctrl.pullup_ctrl_b  = NIB_ZERO;
            next_state.latch     = LATCH_RST;
            next_state.push_pull = PUSH_PULL_RST;
            next_state.osc       = OSC_ONCHIP;
            // General byte keeps whatever it held; software must set it
        end else begin
            unique case (state.phase)
                SRI_RESET: begin
                    // Leave reset with every value exactly as reset left it
                    next_state.phase = SRI_RUN;
                end
                SRI_RUN: begin
                    if (PC_LOAD) begin
                        next_state.pc = PC_VALUE;
                    end else if (PC_STEP) begin
                        next_state.pc = state.pc + 14'h0001;
                    end

                    // Set wins over clear in the same cycle
                    next_state.flags = (state.flags & ~FLAG_CLR) | FLAG_SET;

                    if (REG_WR) begin
                        unique case (REG_SEL)
                            SEL_IRQ_CTRL_A:    next_state.ctrl.irq_ctrl_a     = REG_WDATA;
                            SEL_IRQ_CTRL_B:    next_state.ctrl.irq_ctrl_b     = REG_WDATA;
                            SEL_EXT_IRQ_CFG_A: next_state.ctrl.ext_irq_cfg_a  = REG_WDATA;
                            SEL_TMR_CTRL_SIX:  next_state.ctrl.tmr_ctrl_six   = REG_WDATA;
                            SEL_CLOCK_MODE:    next_state.ctrl.clock_mode_reg = REG_WDATA;
                            SEL_ADC_CTRL_A:    next_state.ctrl.adc_ctrl_a     = REG_WDATA;
                            SEL_ADC_CTRL_B:    next_state.ctrl.adc_ctrl_b     = REG_WDATA;
                            SEL_WAKEUP_CTRL_A: next_state.ctrl.wakeup_ctrl_a  = REG_WDATA;
                            SEL_WAKEUP_CTRL_B: next_state.ctrl.wakeup_ctrl_b  = REG_WDATA;
                            SEL_PULLUP_CTRL_A: next_state.ctrl.pullup_ctrl_a  = REG_WDATA;
                            SEL_PULLUP_CTRL_B: next_state.ctrl.pullup_ctrl_b  = REG_WDATA;
                            default: begin
                            end
                        endcase
                    end

                    if (LATCH_WR) begin
                        next_state.latch = LATCH_WDATA;
                    end
                    if (STRUC_WR) begin
                        next_state.push_pull = STRUC_WDATA;
                    end
                    if (OSC_WR) begin
                        next_state.osc = OSC_WSEL;
                    end
                    if (GEN_WR) begin
                        next_state.gen = GEN_WDATA;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register

    // RESETN is the block's own start-up; the general byte is defined only
    // here so simulation never shows unknowns, not by a system reset
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            state.phase     <= SRI_RESET;
            state.low_cnt   <= '0;
            state.pc        <= PC_RST;
            state.flags     <= FLAGS_RST;
            state.ctrl      <= '{clock_mode_reg: CLOCK_MODE_RST, default: NIB_ZERO};
            state.latch     <= LATCH_RST;
            state.push_pull <= PUSH_PULL_RST;
            state.osc       <= OSC_ONCHIP;
            state.gen       <= GEN_RST;
        end else if (CE) begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign SYS_RESET_N     = (state.phase == SRI_RUN);
    assign CPU_RUN         = (state.phase == SRI_RUN);
    assign PROGRAM_COUNTER = state.pc;
    assign FLAGS           = state.flags;
    assign CTRL            = state.ctrl;
    assign GEN_BYTE        = state.gen;
    assign P0_PULLUP       = state.ctrl.pullup_ctrl_a;
    assign P1_PULLUP       = state.ctrl.pullup_ctrl_b;
    assign OSC_SRC         = state.osc;

    // On-chip oscillator always runs; one other runs only when selected
    always_comb begin
        OSC_RUN = 4'h1;
        OSC_RUN[state.osc] = 1'b1;
    end

    // Open-drain bits only pull low, so a latch of one floats the pin.
    // Ports beyond P1 have no structure control and stay open-drain.
    genvar i;
    generate
        for (i = 0; i < LATCH_W; i++) begin : g_pin
            if (i < STRUC_W) begin : g_sel
                assign PORT_OUT[i] = state.push_pull[i] & state.latch[i];
                assign PORT_OE[i]  = state.push_pull[i] | ~state.latch[i];
            end else begin : g_od
                assign PORT_OUT[i] = 1'b0;
                assign PORT_OE[i]  = ~state.latch[i];
            end
        end
    endgenerate

    // Counter pin is driven low throughout reset
    assign COUNTER_IO_PIN_OUT = (state.phase == SRI_RUN) ? COUNTER_DRIVE : 1'b0;
    assign COUNTER_IO_PIN_OE  = (state.phase == SRI_RUN) ? COUNTER_DRIVE_EN : 1'b1;

endmodule

// ==== design/sri_sync.sv ====
`timescale 1ns/1ps

module sri_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and control
    input  wire logic         MCLK,
    input  wire logic         RESETN,
    input  wire logic         CE,
    // Data
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);

    logic [W-1:0] stage1;

    // Stage one feeds stage two only
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            stage1 <= RST;
            Q      <= RST;
        end else if (CE) begin
            stage1 <= D;
            Q      <= stage1;
        end
    end

endmodule

// ==== test/sri_reset_init_assertions.sv ====
`timescale 1ns/1ps

module sri_reset_init_chk
    import sri_pkg::*;
(
    // Clock and reset sources
    input wire logic                MCLK,
    input wire logic                RESETN,
    input wire logic                RESET_PIN_N,
    input wire logic                POR,
    // Reset status and state
    input wire logic                SYS_RESET_N,
    input wire logic                CPU_RUN,
    input wire logic [13:0]         PROGRAM_COUNTER,
    input wire sri_pkg::sri_flags_t FLAGS,
    input wire sri_pkg::sri_ctrl_t  CTRL,
    input wire logic [7:0]          GEN_BYTE,
    // Pins and oscillators
    input wire logic [23:0]         PORT_OUT,
    input wire logic [23:0]         PORT_OE,
    input wire logic                COUNTER_IO_PIN_OUT,
    input wire logic                COUNTER_IO_PIN_OE,
    input wire logic [3:0]          P0_PULLUP,
    input wire logic [3:0]          P1_PULLUP,
    input wire sri_pkg::sri_osc_t   OSC_SRC,
    input wire logic [3:0]          OSC_RUN
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    // Two sync stages plus the state register bound the reaction time
    chk_pin_takes: assert property (!RESET_PIN_N |-> ##[1:4] !SYS_RESET_N)
        else $error("pin low did not reset");
    chk_por_takes: assert property (POR |-> ##[1:4] !SYS_RESET_N)
        else $error("power-on reset ignored");
    chk_release_wait: assert property ((RESET_PIN_N && !POR) [*5] |-> SYS_RESET_N)
        else $error("reset not released");
    chk_run_mirror: assert property (CPU_RUN == SYS_RESET_N)
        else $error("run and reset status disagree");
    chk_reset_pc: assert property (!SYS_RESET_N |-> PROGRAM_COUNTER == 14'h0000)
        else $error("program counter not zero in reset");
    chk_reset_flags: assert property (!SYS_RESET_N |-> FLAGS == 12'h004)
        else $error("flags wrong in reset");
    chk_reset_ctrl: assert property (!SYS_RESET_N |-> CTRL == 44'h0000f000000)
        else $error("control registers wrong in reset");
    chk_reset_pins: assert property (!SYS_RESET_N |-> PORT_OE == 24'h0 && PORT_OUT == 24'h0
        && P0_PULLUP == 4'h0 && P1_PULLUP == 4'h0 && !COUNTER_IO_PIN_OUT && COUNTER_IO_PIN_OE)
        else $error("pins wrong in reset");
    chk_reset_osc: assert property (!SYS_RESET_N |-> OSC_SRC == OSC_ONCHIP && OSC_RUN == 4'h1)
        else $error("oscillators wrong in reset");
    chk_release_keeps: assert property ($rose(SYS_RESET_N) |-> PROGRAM_COUNTER == 14'h0000
        && $stable(FLAGS) && $stable(CTRL) && $stable(PORT_OE))
        else $error("state changed at release");
    // Start-up reset clears the byte on purpose, so the edge just after it is skipped
    chk_gen_untouched: assert property (!SYS_RESET_N && $past(RESETN) |-> $stable(GEN_BYTE))
        else $error("general byte changed by system reset");
endmodule

bind sri_reset_init sri_reset_init_chk i_chk (
    .MCLK(MCLK), .RESETN(RESETN), .RESET_PIN_N(RESET_PIN_N), .POR(POR),
    .SYS_RESET_N(SYS_RESET_N), .CPU_RUN(CPU_RUN), .PROGRAM_COUNTER(PROGRAM_COUNTER),
    .FLAGS(FLAGS), .CTRL(CTRL), .GEN_BYTE(GEN_BYTE), .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE),
    .COUNTER_IO_PIN_OUT(COUNTER_IO_PIN_OUT), .COUNTER_IO_PIN_OE(COUNTER_IO_PIN_OE),
    .P0_PULLUP(P0_PULLUP), .P1_PULLUP(P1_PULLUP), .OSC_SRC(OSC_SRC), .OSC_RUN(OSC_RUN)
);

// ==== test/sri_reset_init_tb.sv ====
`timescale 1ns/1ps

module sri_reset_init_tb;
    import sri_pkg::*;

    logic        mclk = 1'b0, resetn = 1'b0, por = 1'b0, rst_go = 1'b0, pin_n, ce = 1'b1;
    logic        pc_step = 1'b0, pc_load = 1'b0, reg_wr = 1'b0, latch_wr = 1'b0;
    logic        struc_wr = 1'b0, osc_wr = 1'b0, gen_wr = 1'b0, cnt_drive = 1'b0, cnt_en = 1'b0;
    logic [3:0]  rst_len = 4'h1, reg_wdata = 4'h0, pu0, pu1, osc_run;
    logic [13:0] pc_value = 14'h0000, pc;
    logic [23:0] latch_wdata = 24'h0, port_out, port_oe;
    logic [14:0] struc_wdata = 15'h0;
    logic [7:0]  gen_wdata = 8'h00, gen_byte, gen_exp = 8'h00;
    sri_sel_t    reg_sel = SEL_IRQ_CTRL_A;
    sri_flags_t  flag_set = '0, flag_clr = '0, flags;
    sri_osc_t    osc_wsel = OSC_ONCHIP, osc_src;
    sri_ctrl_t   ctrl;
    logic        sys_reset_n, cpu_run, cnt_out, cnt_oe;
    int          n_mismatch = 0, checks = 0, cycles = 0;

    sri_reset_source i_src (.mclk(mclk), .start(rst_go), .len(rst_len), .reset_pin_n(pin_n));

    // Every input is driven by the bench, clock enable included
    sri_reset_init i_dut (
        .MCLK(mclk), .RESETN(resetn), .CE(ce), .RESET_PIN_N(pin_n), .POR(por),
        .PC_STEP(pc_step), .PC_LOAD(pc_load), .PC_VALUE(pc_value),
        .REG_WR(reg_wr), .REG_SEL(reg_sel), .REG_WDATA(reg_wdata), .FLAG_SET(flag_set), .FLAG_CLR(flag_clr),
        .LATCH_WR(latch_wr), .LATCH_WDATA(latch_wdata), .STRUC_WR(struc_wr), .STRUC_WDATA(struc_wdata),
        .OSC_WR(osc_wr), .OSC_WSEL(osc_wsel), .GEN_WR(gen_wr), .GEN_WDATA(gen_wdata),
        .COUNTER_DRIVE(cnt_drive), .COUNTER_DRIVE_EN(cnt_en), .SYS_RESET_N(sys_reset_n), .CPU_RUN(cpu_run),
        .PROGRAM_COUNTER(pc), .FLAGS(flags), .CTRL(ctrl), .GEN_BYTE(gen_byte), .PORT_OUT(port_out),
        .PORT_OE(port_oe), .COUNTER_IO_PIN_OUT(cnt_out), .COUNTER_IO_PIN_OE(cnt_oe), .P0_PULLUP(pu0),
        .P1_PULLUP(pu1), .OSC_SRC(osc_src), .OSC_RUN(osc_run)
    );

    initial begin
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles > 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic cmp(input string nm, input logic [47:0] exp, input logic [47:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // Push-pull bits drive the latch; open-drain bits only pull low
    function automatic logic [47:0] pins(input logic [23:0] lat, input logic [14:0] st);
        logic [23:0] pp;
        pp = {9'h000, st};
        return {pp | ~lat, pp & lat};
    endfunction

    task automatic wait_sys(input logic lvl);
        int i;
        i = 0;
        while (sys_reset_n !== lvl && i < 50) begin
            @(posedge mclk);
            #1;
            i++;
        end
        cmp("SYS_RESET_N", 48'(lvl), 48'(sys_reset_n));
    endtask

    task automatic check_reset();
        sri_flags_t f;
        f = '0;
        f.wdog_enable_flag = 1'b1;
        cmp("CPU_RUN", 48'(sys_reset_n), 48'(cpu_run));
        cmp("PROGRAM_COUNTER", 48'h0, 48'(pc));
        cmp("FLAGS", 48'(f), 48'(flags));
        for (int s = 0; s < 11; s++) begin
            cmp("CTRL", (s == 4) ? 48'hf : 48'h0, 48'(ctrl[43-4*s -: 4]));
        end
        cmp("PORT", 48'h0, {port_oe, port_out});
        cmp("PULLUP", 48'h0, 48'({pu0, pu1}));
        cmp("OSC", 48'h1, 48'({osc_src, osc_run}));
        cmp("GEN_BYTE", 48'(gen_exp), 48'(gen_byte));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic scramble();
        logic [3:0]  d;
        logic [23:0] lat;
        logic [14:0] st;
        logic [13:0] pv;
        logic [7:0]  pu;
        sri_flags_t  fs, fc;
        sri_osc_t    os;
        for (int s = 0; s < 11; s++) begin
            d = 4'($urandom);
            @(posedge mclk);
            reg_wr <= 1'b1;
            reg_sel <= sri_sel_t'(s);
            reg_wdata <= d;
            @(posedge mclk);
            reg_wr <= 1'b0;
            #1;
            cmp("CTRL", 48'(d), 48'(ctrl[43-4*s -: 4]));
            if (s == 9) begin
                pu[7:4] = d;
            end
            if (s == 10) begin
                pu[3:0] = d;
            end
        end
        cmp("PULLUP", 48'(pu), 48'({pu0, pu1}));
        // A write offered while the clock enable is low must be lost
        @(posedge mclk);
        ce <= 1'b0;
        reg_wr <= 1'b1;
        reg_wdata <= ~d;
        @(posedge mclk);
        ce <= 1'b1;
        reg_wr <= 1'b0;
        #1;
        cmp("CTRL", 48'(d), 48'(ctrl[3:0]));
        fs = sri_flags_t'(12'($urandom));
        fc = sri_flags_t'(12'($urandom));
        lat = 24'($urandom);
        st = 15'($urandom);
        os = sri_osc_t'(2'($urandom));
        pv = 14'($urandom);
        gen_exp = 8'($urandom);
        @(posedge mclk);
        flag_set <= fs;
        flag_clr <= '1;
        {latch_wr, struc_wr, osc_wr, gen_wr, pc_load, pc_step} <= 6'h3f;
        {latch_wdata, struc_wdata, osc_wsel, gen_wdata, pc_value} <= {lat, st, os, gen_exp, pv};
        {cnt_drive, cnt_en} <= 2'($urandom);
        @(posedge mclk);
        {latch_wr, struc_wr, osc_wr, gen_wr, pc_load} <= 5'h00;
        flag_set <= '0;
        flag_clr <= fc;
        #1;
        cmp("FLAGS", 48'(fs), 48'(flags));
        cmp("PROGRAM_COUNTER", 48'(pv), 48'(pc));
        cmp("GEN_BYTE", 48'(gen_exp), 48'(gen_byte));
        cmp("OSC", 48'({os, 4'h1 | (4'h1 << os)}), 48'({osc_src, osc_run}));
        cmp("PORT", pins(lat, st), {port_oe, port_out});
        cmp("COUNTER", 48'({cnt_en, cnt_drive}), 48'({cnt_oe, cnt_out}));
        @(posedge mclk);
        flag_clr <= '0;
        pc_step <= 1'b0;
        #1;
        cmp("FLAGS", 48'(fs & ~fc), 48'(flags));
        cmp("PROGRAM_COUNTER", 48'(14'(pv + 14'h1)), 48'(pc));
    endtask

    initial begin
        void'($urandom(32'h0ffc409d));
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        wait_sys(1'b1);
        check_reset();
        $display("test startup done");
        for (int t = 0; t < 6; t++) begin
            scramble();
            @(posedge mclk);
            if (t % 2 == 0) begin
                rst_go <= 1'b1;
                rst_len <= (t == 0) ? 4'h1 : 4'(1 + $urandom % 8);
                @(posedge mclk);
                rst_go <= 1'b0;
                #1;
                wait_sys(1'b0);
                check_reset();
            end else begin
                por <= 1'b1;
                wait_sys(1'b0);
                check_reset();
                // Requests while held in reset must be dropped
                @(posedge mclk);
                {reg_wr, gen_wr, pc_load} <= 3'h7;
                reg_sel <= SEL_CLOCK_MODE;
                gen_wdata <= ~gen_exp;
                flag_set <= '1;
                @(posedge mclk);
                {reg_wr, gen_wr, pc_load, por} <= 4'h0;
                flag_set <= '0;
            end
            wait_sys(1'b1);
            check_reset();
            $display("test %0d done", t);
        end
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        gen_exp = 8'h00;
        wait_sys(1'b1);
        check_reset();
        $display("test restart done");
        tally_and_finish();
    end
endmodule

// ==== test/sri_reset_source.sv ====
`timescale 1ns/1ps

module sri_reset_source (
    // Clock and request
    input  wire logic       mclk,
    input  wire logic       start,
    input  wire logic [3:0] len,
    // Reset pin
    output logic            reset_pin_n
);
    logic [3:0] cnt = 4'h0;

    initial reset_pin_n = 1'b1;

    // A length of zero is stretched to one cycle, the shortest legal pulse
    always @(posedge mclk) begin
        if (start) begin
            cnt <= (len == 4'h0) ? 4'h1 : len;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        reset_pin_n <= !(start || cnt > 4'h1);
    end
endmodule
